// ==== rtl/boc_pkg.sv ====
package boc_pkg;

  // ------------------------------------------------------------
  // Register map (index; byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_THRESHOLD = 8'h30;
  localparam logic [7:0] IDX_EXACT_A   = 8'h31;
  localparam logic [7:0] IDX_EXACT_B   = 8'h32;
  localparam logic [7:0] IDX_CONTROL   = 8'h33;
  localparam logic [7:0] IDX_IRQ_STAT  = 8'h40;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'h41;
  localparam logic [7:0] IDX_IRQ_EN    = 8'h42;

  // ------------------------------------------------------------
  // Fields and reset values
  // ------------------------------------------------------------
  localparam int         CTRL_ON_BIT     = 0;
  localparam int         CTRL_OK_BIT     = 1;
  localparam int         CTRL_EXLO_BIT   = 2;
  localparam int         CTRL_EXHI_LSB   = 5;
  localparam int         CODE_TOP_BIT    = 5;
  localparam logic [5:0] CODE_RESET      = 6'h3F;
  localparam logic [7:0] EXACT_B_RESET   = 8'h00;
  localparam logic [2:0] EXACT_HI_RESET  = 3'h0;
  localparam int         IRQ_PG_LOST     = 0;
  localparam int         IRQ_CLAMP       = 1;
  localparam int         IRQ_WIDTH       = 2;

  // ------------------------------------------------------------
  // Threshold levels in millivolts
  // ------------------------------------------------------------
  localparam logic [15:0] LOW_BASE_MV    = 16'h1388;
  localparam logic [15:0] LOW_COARSE_MV  = 16'h07D0;
  localparam logic [15:0] LOW_FINE_MV    = 16'h00FA;
  localparam logic [15:0] HIGH_BASE_MV   = 16'h32C8;
  localparam logic [15:0] HIGH_COARSE_MV = 16'h0FA0;
  localparam logic [15:0] HIGH_FINE_MV   = 16'h01F4;
  localparam logic [15:0] MAX_MV         = 16'h6F54;

  // ------------------------------------------------------------
  // Pin group
  // ------------------------------------------------------------
  localparam int PIN_COUNT = 6;
  typedef struct packed {
    logic supply_valid;
    logic master_request_n;
    logic primary_enable_pin;
    logic boost_enable_pin;
    logic ov_above;
    logic ov_reached;
  } boc_pins_type;

endpackage

// ==== rtl/boc_threshold_decode.sv ====
`timescale 1ns/100ps
module boc_threshold_decode (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // Code in, level out
  input  wire logic [5:0]  ovp_threshold_code,
  output logic      [15:0] threshold_mv
);

  logic [15:0] mv_reg;
  logic [15:0] mv_next;

  always_comb begin
    if (ovp_threshold_code[boc_pkg::CODE_TOP_BIT]) begin
      mv_next = boc_pkg::HIGH_BASE_MV
              + boc_pkg::HIGH_COARSE_MV * {14'h0000, ovp_threshold_code[4:3]}
              + boc_pkg::HIGH_FINE_MV * {13'h0000, ovp_threshold_code[2:0]};
    end else begin
      mv_next = boc_pkg::LOW_BASE_MV
              + boc_pkg::LOW_COARSE_MV * {14'h0000, ovp_threshold_code[4:3]}
              + boc_pkg::LOW_FINE_MV * {13'h0000, ovp_threshold_code[2:0]};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      mv_reg <= boc_pkg::MAX_MV;
    end else begin
      mv_reg <= mv_next;
    end
  end

  assign threshold_mv = mv_reg;

endmodule // boc_threshold_decode

// ==== rtl/boc_boost_control.sv ====
`timescale 1ns/100ps
module boc_boost_control (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_b,
  // Avalon-MM slave
  input  wire logic [9:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [3:0]           avs_byteenable,
  input  wire logic [31:0]          avs_writedata,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  // Pins and comparator levels
  input  wire boc_pkg::boc_pins_type pins,
  // Converter control
  output logic                      boost_converter_on,
  output logic                      ovp_clamp,
  output logic      [15:0]          ovp_threshold_mv,
  output logic                      irq
);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [boc_pkg::PIN_COUNT-1:0] meta_reg;
  logic [boc_pkg::PIN_COUNT-1:0] sync_reg;
  boc_pkg::boc_pins_type         pin_s;

  genvar gi;
  generate
    for (gi = 0; gi < boc_pkg::PIN_COUNT; gi++) begin : g_sync
      always_ff @(posedge clock) begin
        if (!rst_b) begin
          meta_reg[gi] <= 1'b0;
          sync_reg[gi] <= 1'b0;
        end else begin
          meta_reg[gi] <= pins[gi];
          sync_reg[gi] <= meta_reg[gi];
        end
      end
    end
  endgenerate

  assign pin_s = boc_pkg::boc_pins_type'(sync_reg);

  // ------------------------------------------------------------
  // Bus slave and registers
  // ------------------------------------------------------------
  logic                          wait_reg,   wait_next;
  logic [31:0]                   rdata_reg,  rdata_next;
  logic [5:0]                    code_reg,   code_next;
  logic                          sw_on_reg,  sw_on_next;
  logic                          exa_reg,    exa_next;
  logic [7:0]                    exb_reg,    exb_next;
  logic                          exlo_reg,   exlo_next;
  logic [2:0]                    exhi_reg,   exhi_next;
  logic [boc_pkg::IRQ_WIDTH-1:0] stat_reg,   stat_next;
  logic [boc_pkg::IRQ_WIDTH-1:0] en_reg,     en_next;
  logic                          irq_reg,    irq_next;
  logic                          on_reg,     on_next;
  logic                          clamp_reg,  clamp_next;
  logic                          above_d_reg;
  logic                          power_good;
  logic                          eligible;
  logic                          wr_go;
  logic [7:0]                    idx;
  logic [boc_pkg::IRQ_WIDTH-1:0] events;
  logic [boc_pkg::IRQ_WIDTH-1:0] clr;

  assign idx        = avs_address[9:2];
  assign wr_go      = avs_write && !wait_reg && avs_byteenable[0];
  assign power_good = !pin_s.ov_above;
  assign eligible   = pin_s.supply_valid || !pin_s.master_request_n
                   || pin_s.primary_enable_pin;

  always_comb begin
    wait_next  = !((avs_read || avs_write) && wait_reg);
    rdata_next = rdata_reg;
    code_next  = code_reg;
    sw_on_next = sw_on_reg;
    exa_next   = exa_reg;
    exb_next   = exb_reg;
    exlo_next  = exlo_reg;
    exhi_next  = exhi_reg;
    en_next    = en_reg;
    clr        = '0;
    if (avs_read && wait_reg) begin
      rdata_next = 32'h0000_0000;
      unique case (idx)
        boc_pkg::IDX_THRESHOLD: rdata_next[5:0] = code_reg;
        boc_pkg::IDX_EXACT_A:   rdata_next[0] = exa_reg;
        boc_pkg::IDX_EXACT_B:   rdata_next[7:0] = exb_reg;
        boc_pkg::IDX_CONTROL: begin
          rdata_next[boc_pkg::CTRL_ON_BIT]   = sw_on_reg;
          rdata_next[boc_pkg::CTRL_OK_BIT]   = power_good;
          rdata_next[boc_pkg::CTRL_EXLO_BIT] = exlo_reg;
          rdata_next[boc_pkg::CTRL_EXHI_LSB +: 3] = exhi_reg;
        end
        boc_pkg::IDX_IRQ_STAT:  rdata_next[boc_pkg::IRQ_WIDTH-1:0] = stat_reg;
        boc_pkg::IDX_IRQ_EN:    rdata_next[boc_pkg::IRQ_WIDTH-1:0] = en_reg;
        default:                rdata_next = 32'h0000_0000;
      endcase
    end
    if (wr_go) begin
      unique case (idx)
        boc_pkg::IDX_THRESHOLD: code_next = avs_writedata[5:0];
        boc_pkg::IDX_EXACT_A:   exa_next = avs_writedata[0];
        boc_pkg::IDX_EXACT_B:   exb_next = avs_writedata[7:0];
        boc_pkg::IDX_CONTROL: begin
          sw_on_next = avs_writedata[boc_pkg::CTRL_ON_BIT];
          exlo_next  = avs_writedata[boc_pkg::CTRL_EXLO_BIT];
          exhi_next  = avs_writedata[boc_pkg::CTRL_EXHI_LSB +: 3];
        end
        boc_pkg::IDX_IRQ_CLEAR: clr = avs_writedata[boc_pkg::IRQ_WIDTH-1:0];
        boc_pkg::IDX_IRQ_EN:    en_next = avs_writedata[boc_pkg::IRQ_WIDTH-1:0];
        default:                clr = '0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Converter control and events
  // ------------------------------------------------------------
  always_comb begin
    on_next    = eligible && (pin_s.boost_enable_pin || sw_on_reg);
    clamp_next = pin_s.ov_reached || pin_s.ov_above;
    events     = '0;
    events[boc_pkg::IRQ_PG_LOST] = pin_s.ov_above && !above_d_reg;
    events[boc_pkg::IRQ_CLAMP]   = clamp_next && !clamp_reg;
    stat_next  = (stat_reg & ~clr) | events;
    irq_next   = |(stat_next & en_next);
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wait_reg    <= 1'b1;
      rdata_reg   <= 32'h0000_0000;
      code_reg    <= boc_pkg::CODE_RESET;
      sw_on_reg   <= 1'b0;
      exa_reg     <= 1'b0;
      exb_reg     <= boc_pkg::EXACT_B_RESET;
      exlo_reg    <= 1'b0;
      exhi_reg    <= boc_pkg::EXACT_HI_RESET;
      en_reg      <= '0;
      stat_reg    <= '0;
      irq_reg     <= 1'b0;
      on_reg      <= 1'b0;
      clamp_reg   <= 1'b0;
      above_d_reg <= 1'b0;
    end else begin
      wait_reg    <= wait_next;
      rdata_reg   <= rdata_next;
      code_reg    <= code_next;
      sw_on_reg   <= sw_on_next;
      exa_reg     <= exa_next;
      exb_reg     <= exb_next;
      exlo_reg    <= exlo_next;
      exhi_reg    <= exhi_next;
      en_reg      <= en_next;
      stat_reg    <= stat_next;
      irq_reg     <= irq_next;
      on_reg      <= on_next;
      clamp_reg   <= clamp_next;
      above_d_reg <= pin_s.ov_above;
    end
  end

  boc_threshold_decode u_decode (
    .clock              (clock),
    .rst_b              (rst_b),
    .ovp_threshold_code (code_reg),
    .threshold_mv       (ovp_threshold_mv)
  );

  assign avs_readdata       = rdata_reg;
  assign avs_waitrequest    = wait_reg;
  assign boost_converter_on = on_reg;
  assign ovp_clamp          = clamp_reg;
  assign irq                = irq_reg;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence s_thr_write;
    avs_write && !wait_reg && avs_byteenable[0] && idx == boc_pkg::IDX_THRESHOLD;
  endsequence

  sequence s_decode_done;
    ##2 1'b1;
  endsequence

  a_code_reset_max: assert property ($past(!rst_b) |-> code_reg == 6'h3F
                                     && ovp_threshold_mv == 16'h6F54)
    else $error("threshold not at maximum after reset");
  a_code_write_apply: assert property (s_thr_write |=> code_reg == $past(avs_writedata[5:0]))
    else $error("written threshold code not applied");
  a_decode_low_range: assert property (!code_reg[5] && $stable(code_reg) |=>
      ovp_threshold_mv == 16'd5000 + 16'd2000 * $past(code_reg[4:3])
                          + 16'd250 * $past(code_reg[2:0]))
    else $error("low range threshold decode wrong");
  a_decode_high_range: assert property (code_reg[5] && $stable(code_reg) |=>
      ovp_threshold_mv == 16'd13000 + 16'd4000 * $past(code_reg[4:3])
                          + 16'd500 * $past(code_reg[2:0]))
    else $error("high range threshold decode wrong");
  a_write_to_level: assert property (s_thr_write ##1 (code_reg == 6'h00) |->
      s_decode_done ##0 (ovp_threshold_mv == 16'd5000 || code_reg != 6'h00))
    else $error("lowest code does not reach level");
  a_enable_gated: assert property (!eligible |=> !boost_converter_on)
    else $error("converter on while not eligible");
  a_enable_request: assert property (eligible && (pin_s.boost_enable_pin || sw_on_reg)
                                     |=> boost_converter_on)
    else $error("eligible request did not turn converter on");
  a_clamp_follow: assert property (pin_s.ov_reached |=> ovp_clamp)
    else $error("clamp not held at threshold");
  a_pg_clear_read: assert property (avs_read && wait_reg && idx == boc_pkg::IDX_CONTROL
      && pin_s.ov_above |=> !avs_readdata[1])
    else $error("power good read high while above threshold");
  a_pg_set_read: assert property (avs_read && wait_reg && idx == boc_pkg::IDX_CONTROL
      && !pin_s.ov_above |=> avs_readdata[1])
    else $error("power good read low at or below threshold");
  a_bus_one_wait: assert property ((avs_read || avs_write) && wait_reg |=> !avs_waitrequest)
    else $error("waitrequest not released after one cycle");
  a_irq_level: assert property (irq == |($past(stat_next) & $past(en_next)))
    else $error("interrupt level mismatch");

endmodule // boc_boost_control

// ==== bench/boc_board_model.sv ====
`timescale 1ns/100ps
// ------------------------------------------------------------
// Board pins and sense comparator
// ------------------------------------------------------------
module boc_board_model (
  // Clock
  input  wire logic                  clock,
  // Requested pin levels and sense node
  input  wire logic [3:0]            pin_req,
  input  wire logic [15:0]           sense_mv,
  input  wire logic [15:0]           thr_mv,
  // Pins to the block
  output boc_pkg::boc_pins_type      pins
);
  // Pins change only after an edge, like a real board
  always_ff @(posedge clock) begin
    pins <= {pin_req, sense_mv > thr_mv, sense_mv >= thr_mv};
  end
endmodule // boc_board_model

// ==== bench/boc_boost_control_test.sv ====
`timescale 1ns/100ps
module boc_boost_control_test;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic                  clock;
  logic                  rst_b;
  logic [9:0]            avs_address;
  logic                  avs_read;
  logic                  avs_write;
  logic [3:0]            avs_byteenable;
  logic [31:0]           avs_writedata;
  logic [31:0]           avs_readdata;
  logic                  avs_waitrequest;
  boc_pkg::boc_pins_type pins;
  logic                  boost_converter_on;
  logic                  ovp_clamp;
  logic [15:0]           ovp_threshold_mv;
  logic                  irq;
  logic [3:0]            pin_req;
  logic [15:0]           sense_mv;
  logic [31:0]           rd;
  int                    error_cnt;
  int                    samples_checked;
  int                    thr;
  int                    c;
  int                    m_stat;
  int                    m_en;
  logic                  m_above;
  logic                  m_clamp;
  int                    exp_q[$];

  boc_boost_control boc_boost_control_inst (
    .clock(clock), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pins(pins),
    .boost_converter_on(boost_converter_on), .ovp_clamp(ovp_clamp),
    .ovp_threshold_mv(ovp_threshold_mv), .irq(irq));

  boc_board_model boc_board_model_inst (
    .clock(clock), .pin_req(pin_req), .sense_mv(sense_mv), .thr_mv(ovp_threshold_mv),
    .pins(pins));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // One bus cycle, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    avs_address   <= {idx, 2'b00};
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= {24'h00_0000, wd};
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    // Model follows the interrupt clear and enable writes
    if (wr && avs_byteenable[0] && idx == 8'h41) m_stat = m_stat & ~int'(wd);
    if (wr && avs_byteenable[0] && idx == 8'h42) m_en = int'(wd[1:0]);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clock);
  endtask

  function automatic int exp_mv(input logic [5:0] v);
    if (v[5]) return 13000 + 4000 * v[4:3] + 500 * v[2:0];
    return 5000 + 2000 * v[4:3] + 250 * v[2:0];
  endfunction

  // Expected flags: clamp, power good, status[1:0], irq
  task automatic probe(input int off, input logic [4:0] e);
    if (off > 0 && !m_above) m_stat = m_stat | 1;
    if (off >= 0 && !m_clamp) m_stat = m_stat | 2;
    m_above = (off > 0);
    m_clamp = (off >= 0);
    sense_mv <= 16'(thr + off);
    repeat (8) @(posedge clock);
    check(ovp_clamp, e[4]);
    check(ovp_clamp, m_clamp);
    bus(1'b0, 8'h33, 8'h00);
    check(rd[1], e[3]);
    check(rd[1], !m_above);
    bus(1'b0, 8'h40, 8'h00);
    check(rd, e[2:1]);
    check(rd, 32'(m_stat));
    check(irq, e[0]);
    check(irq, |(m_stat & m_en));
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'h1;
    avs_writedata = '0;
    pin_req = 4'h0;
    sense_mv = '0;
    error_cnt = 0;
    samples_checked = 0;
    m_stat = 0;
    m_en = 0;
    m_above = 1'b0;
    m_clamp = 1'b0;
    c = $urandom(32'h0233);
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
    check(ovp_threshold_mv, 32'h0000_6F54);
    check(boost_converter_on, 1'b0);
    bus(1'b0, 8'h30, 8'h00);
    check(rd, 32'h0000_003F);
    c = $urandom % 64;
    for (int i = 0; i < 64; i++) begin
      bus(1'b1, 8'h30, 8'hC0 | 8'(c));
      exp_q.push_back(exp_mv(c[5:0]));
      repeat (4) @(posedge clock);
      check(ovp_threshold_mv, 32'(exp_q.pop_front()));
      bus(1'b0, 8'h30, 8'h00);
      check(rd, 32'(c[5:0]));
      c = (c + 1) % 64;
    end
    for (int i = 0; i < 32; i++) begin
      pin_req <= i[4:1];
      bus(1'b1, 8'h33, {3'b000, 2'b11, 2'b00, i[0]});
      repeat (5) @(posedge clock);
      check(boost_converter_on, (i[4] | !i[3] | i[2]) & (i[1] | i[0]));
      bus(1'b0, 8'h33, 8'h00);
      check(rd, {30'h0, 1'b1, i[0]});
    end
    pin_req <= 4'h0;
    c = 32 + $urandom % 32;
    bus(1'b1, 8'h30, 8'(c));
    thr = exp_mv(c[5:0]);
    bus(1'b1, 8'h42, 8'h03);
    bus(1'b1, 8'h41, 8'h03);
    probe(-1000, 5'b01000);
    probe(0, 5'b11101);
    probe(1000, 5'b10111);
    bus(1'b1, 8'h41, 8'h03);
    probe(1000, 5'b10000);
    bus(1'b1, 8'h42, 8'h00);
    probe(-1000, 5'b01000);
    probe(1000, 5'b10110);
    bus(1'b1, 8'h42, 8'h01);
    repeat (2) @(posedge clock);
    check(irq, 1'b1);
    bus(1'b1, 8'h41, 8'h01);
    probe(1000, 5'b10100);
    bus(1'b0, 8'h41, 8'h00);
    check(rd, 32'h0000_0000);
    bus(1'b1, 8'h50, 8'hFF);
    bus(1'b0, 8'h50, 8'h00);
    check(rd, 32'h0000_0000);
    avs_byteenable <= 4'h0;
    bus(1'b1, 8'h30, 8'h00);
    avs_byteenable <= 4'h1;
    bus(1'b0, 8'h30, 8'h00);
    check(rd, 32'(c[5:0]));
    // Mid-run reset brings back the highest threshold
    sense_mv <= '0;
    rst_b    <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
    check(ovp_threshold_mv, 32'h0000_6F54);
    check(boost_converter_on, 1'b0);
    check(irq, 1'b0);
    bus(1'b0, 8'h30, 8'h00);
    check(rd, 32'h0000_003F);
    tally_and_finish();
  end

  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    tally_and_finish();
  end
endmodule // boc_boost_control_test
